// ===== hw/pmu_resource_sequencer.sv
/*
 * Power manager resource sequencer with an APB register file.
 * Assumes synchronous inputs to pclk; core clock requests are levels.
 */
// The APB register port and the address map were decided locally.
`timescale 1ns/1ns
`default_nettype none
module pmu_resource_sequencer
    import pmu_seq_pkg::*;
(
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // requests and power pins
    input wire logic [1:0] core_clk_req,
    input wire logic reg_on_in,
    input wire logic hibernate_power_request_in,
    // resource and regulator controls
    output logic [NUM_RES-1:0] resource_enable,
    output logic [NUM_RES-1:0] resource_enable_oe,
    output logic regulator_enable,
    output logic core_reset_n,
    output logic reg_on_pulldown_en,
    output logic hibernate_power_request_out,
    output logic reference_clock_buffer_en,
    output logic main_clock_en
);
    typedef enum logic [1:0] {RES_OFF, RES_UP, RES_ON, RES_DOWN} res_state_t;

    logic [3:0] ctrl_reg;
    logic [NUM_RES-1:0] minimum_resource_mask;
    logic [NUM_RES-1:0] resource_on_flag;
    logic [NUM_RES-1:0] transition_in_progress_flag;
    logic [15:0] timer_req_reg;
    logic [NUM_RES-1:0] required_reg;
    logic [NUM_RES-1:0] dep_reg [NUM_RES];
    logic [31:0] dly_reg [NUM_RES];
    logic [DELAY_W-1:0] cnt_reg [NUM_RES];
    logic [DIV_W-1:0] div_reg;
    logic tick;
    logic [2:0] cold_cnt_reg;

    wire shutdown = ctrl_reg[CTRL_SHUTDOWN_BIT];
    // power-on pin low or hibernate low clears run: resources, regulators and clocks go off and core reset is held
    wire power_ok = reg_on_in & hibernate_power_request_in;
    wire run = power_ok & ~shutdown;

    // core clock requests map to fixed resource sets (low two resources
    // feed the reference, upper ones the pll); dependencies add the rest
    wire [NUM_RES-1:0] clk_map0 = 8'h03;
    wire [NUM_RES-1:0] clk_map1 = 8'h0F;
    wire [NUM_RES-1:0] clk_need = (core_clk_req[0] ? clk_map0 : '0) |
        (core_clk_req[1] ? clk_map1 : '0);
    wire [NUM_RES-1:0] timer_need = (timer_req_reg[15:8] != 8'h00) ?
        timer_req_reg[7:0] : '0;
    wire [NUM_RES-1:0] direct_req = clk_need | minimum_resource_mask |
        timer_need;

    // dependency closure, one level per pass over the table
    logic [NUM_RES-1:0] closure [NUM_RES+1];
    assign closure[0] = direct_req;
    genvar gi, gj;
    generate
        for (gi = 0; gi < NUM_RES; gi++) begin : g_close
            logic [NUM_RES-1:0] add;
            always_comb begin
                add = closure[gi];
                for (int k = 0; k < NUM_RES; k++) begin
                    if (closure[gi][k]) begin
                        add = add | dep_reg[k];
                    end
                end
            end
            assign closure[gi+1] = add;
        end
    endgenerate
    wire [NUM_RES-1:0] required = closure[NUM_RES];

    // a resource has a powered dependent if some on/ramping resource lists it
    logic [NUM_RES-1:0] powered_dep;
    logic [NUM_RES-1:0] deps_ready;
    logic [NUM_RES-1:0] start_up;
    logic [NUM_RES-1:0] start_down;
    logic [NUM_RES-1:0] done;
    wire [NUM_RES-1:0] powered = resource_on_flag | transition_in_progress_flag;
    generate
        for (gj = 0; gj < NUM_RES; gj++) begin : g_res
            logic pd;
            always_comb begin
                pd = 1'b0;
                for (int k = 0; k < NUM_RES; k++) begin
                    if (powered[k] && dep_reg[k][gj] && k != gj) begin
                        pd = 1'b1;
                    end
                end
            end
            assign powered_dep[gj] = pd;
            assign deps_ready[gj] =
                ((dep_reg[gj] & ~resource_on_flag & ~(8'h01 << gj)) == '0);
            wire settled = ~transition_in_progress_flag[gj];
            assign start_up[gj] = settled & ~resource_on_flag[gj] &
                required[gj] & deps_ready[gj];
            assign start_down[gj] = settled & resource_on_flag[gj] &
                ~required[gj] & ~powered_dep[gj];
            assign done[gj] = transition_in_progress_flag[gj] &&
                cnt_reg[gj] == DELAY_W'(1);
            wire [DELAY_W-1:0] on_dly = dly_reg[gj][DELAY_W-1:0];
            wire [DELAY_W-1:0] off_dly = dly_reg[gj][DELAY_W+7:8];

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cnt_reg[gj] <= '0;
                    resource_on_flag[gj] <= 1'b0;
                    transition_in_progress_flag[gj] <= 1'b0;
                end else if (!run) begin
                    cnt_reg[gj] <= '0;
                    resource_on_flag[gj] <= 1'b0;
                    transition_in_progress_flag[gj] <= 1'b0;
                end else if (tick) begin
                    if (transition_in_progress_flag[gj]) begin
                        cnt_reg[gj] <= cnt_reg[gj] - DELAY_W'(1);
                        if (done[gj]) begin
                            transition_in_progress_flag[gj] <= 1'b0;
                            resource_on_flag[gj] <= ~resource_on_flag[gj];
                        end
                    end else if (start_up[gj]) begin
                        if (on_dly == '0) begin
                            resource_on_flag[gj] <= 1'b1;
                        end else begin
                            cnt_reg[gj] <= on_dly;
                            transition_in_progress_flag[gj] <= 1'b1;
                        end
                    end else if (start_down[gj]) begin
                        if (off_dly == '0) begin
                            resource_on_flag[gj] <= 1'b0;
                        end else begin
                            cnt_reg[gj] <= off_dly;
                            transition_in_progress_flag[gj] <= 1'b1;
                        end
                    end
                end
            end

            ttimer_zero_a: assert property (
                @(posedge pclk) disable iff (!presetn)
                !transition_in_progress_flag[gj] |-> cnt_reg[gj] == '0)
                else $error("settled resource with nonzero timer");
            ramp_nonzero_a: assert property (
                @(posedge pclk) disable iff (!presetn)
                transition_in_progress_flag[gj] |-> cnt_reg[gj] != '0)
                else $error("ramping resource with zero timer");
            ramp_end_a: assert property (
                @(posedge pclk) disable iff (!presetn)
                run && tick && done[gj] |=>
                resource_on_flag[gj] != $past(resource_on_flag[gj]))
                else $error("ramp end did not toggle state");
            up_guard_a: assert property (
                @(posedge pclk) disable iff (!presetn)
                $rose(powered[gj]) |-> $past(required[gj] && deps_ready[gj]))
                else $error("resource started without dependencies");
            // checked where the disable starts: a timed ramp may end after
            // the request has come back, which is legal
            down_guard_a: assert property (
                @(posedge pclk) disable iff (!presetn)
                $past(run) && $past(resource_on_flag[gj]) &&
                !$past(transition_in_progress_flag[gj]) &&
                (!resource_on_flag[gj] || transition_in_progress_flag[gj])
                |-> $past(!required[gj] && !powered_dep[gj]))
                else $error("resource dropped while still needed");
        end
    endgenerate

    function automatic res_state_t res_state(input logic on, input logic pend);
        res_state_t s;
        if (pend) begin
            s = on ? RES_DOWN : RES_UP;
        end else begin
            s = on ? RES_ON : RES_OFF;
        end
        return s;
    endfunction
    res_state_t res0_state;
    assign res0_state = res_state(resource_on_flag[0],
        transition_in_progress_flag[0]);

    // low-power tick divider; request timer counts down in ticks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_reg <= '0;
            tick <= 1'b0;
        end else begin
            tick <= (div_reg == DIV_W'(LP_DIV - 1));
            div_reg <= (div_reg == DIV_W'(LP_DIV - 1)) ? '0 :
                div_reg + DIV_W'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            required_reg <= '0;
        end else if (tick) begin
            required_reg <= required;
        end
    end

    // apb slave: zero wait states, unmapped reads zero with pslverr
    wire acc = psel & penable;
    wire wr = acc & pwrite;
    wire [3:0] idx = paddr[5:2];
    wire in_dep = paddr[11:6] == ADDR_DEP_BASE[11:6] && idx < 4'(NUM_RES);
    wire in_dly = paddr[11:6] == ADDR_DLY_BASE[11:6] && idx < 4'(NUM_RES);
    wire in_cnt = paddr[11:6] == ADDR_CNT_BASE[11:6] && idx < 4'(NUM_RES);
    wire hit_ctrl = paddr == ADDR_CTRL;
    wire hit_min = paddr == ADDR_MIN;
    wire hit_treq = paddr == ADDR_TIMER_REQ;
    wire [2:0] ridx = idx[2:0];
    logic [31:0] rd_mux;
    logic rd_ok;
    always_comb begin
        rd_ok = 1'b1;
        if (hit_ctrl) begin
            rd_mux = {28'h000_0000, ctrl_reg};
        end else if (hit_min) begin
            rd_mux = {24'h00_0000, minimum_resource_mask};
        end else if (paddr == ADDR_STATE) begin
            rd_mux = {24'h00_0000, resource_on_flag};
        end else if (paddr == ADDR_PEND) begin
            rd_mux = {24'h00_0000, transition_in_progress_flag};
        end else if (hit_treq) begin
            rd_mux = {16'h0000, timer_req_reg};
        end else if (paddr == ADDR_REQUIRED) begin
            rd_mux = {24'h00_0000, required_reg};
        end else if (in_dep) begin
            rd_mux = {24'h00_0000, dep_reg[ridx]};
        end else if (in_dly) begin
            rd_mux = {16'h0000, dly_reg[ridx][15:0]};
        end else if (in_cnt) begin
            rd_mux = {24'h00_0000, cnt_reg[ridx]};
        end else begin
            rd_mux = 32'h0000_0000;
            rd_ok = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= CTRL_RESET;
            minimum_resource_mask <= MIN_RESET;
            timer_req_reg <= TIMER_RESET;
            for (int k = 0; k < NUM_RES; k++) begin
                dep_reg[k] <= '0;
                dly_reg[k] <= DLY_RESET;
            end
        end else begin
            if (wr && hit_ctrl) begin
                ctrl_reg <= pwdata[3:0];
            end
            if (wr && hit_min) begin
                minimum_resource_mask <= pwdata[7:0];
            end
            if (wr && hit_treq) begin
                timer_req_reg <= pwdata[15:0];
            end else if (tick && timer_req_reg[15:8] != 8'h00) begin
                timer_req_reg[15:8] <= timer_req_reg[15:8] - 8'h01;
            end
            if (wr && in_dep) begin
                dep_reg[ridx] <= pwdata[7:0];
            end
            if (wr && in_dly) begin
                dly_reg[ridx] <= {16'h0000, pwdata[15:0]};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~rd_ok;
            prdata <= (psel & ~penable & ~pwrite) ? rd_mux : '0;
        end
    end

    // outputs; cold-start counter keeps reset asserted a few cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cold_cnt_reg <= '0;
            resource_enable <= '0;
            resource_enable_oe <= '0;
            regulator_enable <= 1'b0;
            core_reset_n <= 1'b0;
            reg_on_pulldown_en <= 1'b1;
            hibernate_power_request_out <= 1'b0;
            reference_clock_buffer_en <= 1'b0;
            main_clock_en <= 1'b0;
        end else begin
            cold_cnt_reg <= run ? (cold_cnt_reg == 3'h7 ? cold_cnt_reg :
                cold_cnt_reg + 3'h1) : 3'h0;
            resource_enable <= run ? resource_on_flag : '0;
            resource_enable_oe <= shutdown ? '0 : '1;
            regulator_enable <= power_ok;
            core_reset_n <= run && cold_cnt_reg == 3'h7;
            reg_on_pulldown_en <= ctrl_reg[CTRL_PULLDOWN_BIT];
            hibernate_power_request_out <= hibernate_power_request_in;
            reference_clock_buffer_en <= run & ~ctrl_reg[CTRL_SLEEP_BIT];
            main_clock_en <= run & ~ctrl_reg[CTRL_DOZE_BIT];
        end
    end

    reg_off_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !power_ok |=> !regulator_enable && !core_reset_n)
        else $error("regulators or reset not dropped");
    shutdown_tri_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        shutdown |=> resource_enable_oe == '0 && resource_enable == '0)
        else $error("outputs driven in shutdown");
    sleep_buf_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        ctrl_reg[CTRL_SLEEP_BIT] |=> !reference_clock_buffer_en)
        else $error("reference buffer on in sleep");
    doze_clk_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        ctrl_reg[CTRL_DOZE_BIT] |=> !main_clock_en)
        else $error("main clocks on in doze");
    cold_start_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !run |=> resource_on_flag == '0 && transition_in_progress_flag == '0)
        else $error("state kept across power-down");
    req_union_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        tick |=> (required_reg & $past(direct_req)) == $past(direct_req))
        else $error("direct request missing from required set");

    cov_ramp_up_c: cover property (@(posedge pclk) res0_state == RES_UP);
    cov_ramp_dn_c: cover property (@(posedge pclk) res0_state == RES_DOWN);
    cov_reset_rel_c: cover property (@(posedge pclk) $rose(core_reset_n));
    cov_shutdown_c: cover property (@(posedge pclk) $rose(shutdown));
endmodule // pmu_resource_sequencer
`default_nettype wire

// ===== hw/pmu_seq_pkg.sv
/*
 * Constants for the resource sequencer: register offsets, field layout,
 * reset values and the low-power tick divider.
 * Assumes a 10 MHz pclk and an APB master with 32-bit data.
 */
package pmu_seq_pkg;
    localparam int NUM_RES = 8;
    localparam int DELAY_W = 8;
    // APB register byte offsets; per-resource regs take the resource index from paddr[5:2]
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_MIN = 12'h004;
    localparam logic [11:0] ADDR_STATE = 12'h008;
    localparam logic [11:0] ADDR_PEND = 12'h00C;
    localparam logic [11:0] ADDR_TIMER_REQ = 12'h010;
    localparam logic [11:0] ADDR_REQUIRED = 12'h014;
    localparam logic [11:0] ADDR_DEP_BASE = 12'h040;
    localparam logic [11:0] ADDR_DLY_BASE = 12'h080;
    localparam logic [11:0] ADDR_CNT_BASE = 12'h0C0;
    // ctrl register bit positions
    localparam int CTRL_PULLDOWN_BIT = 0;
    localparam int CTRL_SHUTDOWN_BIT = 1;
    localparam int CTRL_SLEEP_BIT = 2;
    localparam int CTRL_DOZE_BIT = 3;
    localparam logic [3:0] CTRL_RESET = 4'h1;
    localparam logic [7:0] MIN_RESET = 8'h01;
    localparam logic [31:0] DLY_RESET = 32'h0000_0101;
    localparam logic [15:0] TIMER_RESET = 16'h0000;
    // low-power tick: 32.768 kHz from 10 MHz, truncated to whole cycles
    localparam int PCLK_HZ = 10_000_000;
    localparam int LP_HZ = 32_768;
    localparam int LP_DIV = PCLK_HZ / LP_HZ;
    localparam int DIV_W = 9;
endpackage

// ===== verification/core_req_model.sv
/*
 * Model of the requesting cores and the host power pins.
 * Assumes the bench asks for levels; pins change just after pclk edges.
 */
`timescale 1ns/1ns
`default_nettype none
module core_req_model (
    // clock
    input wire logic pclk,
    // bench wishes
    input wire logic [1:0] want_clk,
    input wire logic want_run,
    input wire logic want_hib,
    // pins toward the sequencer
    output logic [1:0] core_clk_req,
    output logic reg_on_in,
    output logic hibernate_power_request_in
);
    // requests are levels held until the core no longer needs the clock
    always @(posedge pclk) begin
        core_clk_req <= want_clk;
        reg_on_in <= want_run;
        hibernate_power_request_in <= want_hib;
    end
endmodule // core_req_model
`default_nettype wire

// ===== verification/tb_pmu_resource_sequencer.sv
/*
 * Self-checking bench for the resource sequencer over APB.
 * Assumes a zero-wait APB slave and a 305-cycle low-power tick.
 */
`timescale 1ns/1ns
`default_nettype none
module tb_pmu_resource_sequencer;
    import pmu_seq_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] core_clk_req, want_clk;
    logic reg_on_in, hib_in, want_run, want_hib, dep_on, err;
    logic [NUM_RES-1:0] resource_enable, resource_enable_oe;
    logic regulator_enable, core_reset_n, pd_en, hib_out, ref_en, main_en;
    int n_mismatch = 0;
    int samples_checked = 0;

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    core_req_model PARTNER (.pclk(pclk), .want_clk(want_clk),
        .want_run(want_run), .want_hib(want_hib),
        .core_clk_req(core_clk_req), .reg_on_in(reg_on_in),
        .hibernate_power_request_in(hib_in));

    pmu_resource_sequencer DUT (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .core_clk_req(core_clk_req),
        .reg_on_in(reg_on_in), .hibernate_power_request_in(hib_in),
        .resource_enable(resource_enable),
        .resource_enable_oe(resource_enable_oe),
        .regulator_enable(regulator_enable), .core_reset_n(core_reset_n),
        .reg_on_pulldown_en(pd_en), .hibernate_power_request_out(hib_out),
        .reference_clock_buffer_en(ref_en), .main_clock_en(main_en));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // one transfer; waits for pready however long it takes
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(rd, exp);
    endtask

    task automatic ticks(input int n);
        repeat (n * LP_DIV) @(posedge pclk);
    endtask

    // while dep_on is set, resource 2 must never be enabled without resource 3
    always @(posedge pclk) begin
        if (dep_on && resource_enable[2] === 1'b1 &&
            resource_enable[3] !== 1'b1) begin
            check(32'h0, 32'h1);
        end
    end

    initial begin
        repeat (60000) @(posedge pclk);
        n_mismatch++;
        results();
    end

    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, dep_on} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        want_clk = 2'b00;
        {want_run, want_hib} = 2'b00;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check(32'(pd_en), 32'h1);
        check({30'h0, regulator_enable, core_reset_n}, 32'h0);
        rd_chk(ADDR_CTRL, 32'(CTRL_RESET));
        rd_chk(ADDR_MIN, 32'(MIN_RESET));
        rd_chk(ADDR_DLY_BASE, DLY_RESET);
        apb(1'b0, 12'hFFC, 32'h0000_0000);
        check({err, rd[30:0]}, 32'h8000_0000);
        // power up; reset lags the regulators
        want_run <= 1'b1;
        want_hib <= 1'b1;
        repeat (3) @(posedge pclk);
        check({31'h0, regulator_enable}, 32'h1);
        repeat (12) @(posedge pclk);
        check(32'(core_reset_n), 32'h1);
        ticks(4);
        rd_chk(ADDR_STATE, 32'h0000_0001);
        check(32'(resource_enable), 32'h0000_0001);
        rd_chk(ADDR_PEND, 32'h0000_0000);
        rd_chk(ADDR_CNT_BASE, 32'h0000_0000);
        want_clk <= 2'b01;
        ticks(4);
        rd_chk(ADDR_STATE, 32'h0000_0003);
        rd_chk(ADDR_REQUIRED, 32'h0000_0003);
        // resource 2 leans on resource 3, which nobody asks for
        apb(1'b1, ADDR_DEP_BASE + 12'h008, 32'h0000_0008);
        rd_chk(ADDR_DEP_BASE + 12'h008, 32'h0000_0008);
        dep_on = 1'b1;
        apb(1'b1, ADDR_MIN, 32'h0000_0005);
        ticks(6);
        rd_chk(ADDR_REQUIRED, 32'h0000_000F);
        rd_chk(ADDR_STATE, 32'h0000_000F);
        // long ramp both ways on resource 5
        apb(1'b1, ADDR_DLY_BASE + 12'h014, 32'h0000_0A0A);
        apb(1'b1, ADDR_MIN, 32'h0000_0025);
        ticks(3);
        rd_chk(ADDR_PEND, 32'h0000_0020);
        apb(1'b0, ADDR_CNT_BASE + 12'h014, 32'h0000_0000);
        check(32'(rd != 0 && rd <= 10), 32'h1);
        ticks(12);
        rd_chk(ADDR_STATE, 32'h0000_002F);
        rd_chk(ADDR_PEND, 32'h0000_0000);
        apb(1'b1, ADDR_MIN, 32'h0000_0005);
        ticks(3);
        rd_chk(ADDR_STATE, 32'h0000_002F);
        rd_chk(ADDR_PEND, 32'h0000_0020);
        ticks(12);
        rd_chk(ADDR_STATE, 32'h0000_000F);
        apb(1'b1, ADDR_MIN, 32'h0000_0001);
        ticks(6);
        rd_chk(ADDR_STATE, 32'h0000_0003);
        dep_on = 1'b0;
        // zero delays switch at once
        apb(1'b1, ADDR_DLY_BASE + 12'h010, 32'h0000_0000);
        apb(1'b1, ADDR_MIN, 32'h0000_0011);
        ticks(2);
        rd_chk(ADDR_STATE, 32'h0000_0013);
        apb(1'b1, ADDR_MIN, 32'h0000_0001);
        ticks(2);
        rd_chk(ADDR_STATE, 32'h0000_0003);
        // request timer asks for resource 6 for ten ticks
        apb(1'b1, ADDR_TIMER_REQ, 32'h0000_0A40);
        ticks(4);
        rd_chk(ADDR_REQUIRED, 32'h0000_0043);
        rd_chk(ADDR_STATE, 32'h0000_0043);
        ticks(10);
        rd_chk(ADDR_STATE, 32'h0000_0003);
        // control bits one at a time
        // control outputs follow the register one edge after the write
        apb(1'b1, ADDR_CTRL, 32'h0000_0000);
        @(posedge pclk);
        check(32'(pd_en), 32'h0);
        apb(1'b1, ADDR_CTRL, 32'h0000_0004);
        @(posedge pclk);
        check({30'h0, ref_en, main_en}, 32'h1);
        apb(1'b1, ADDR_CTRL, 32'h0000_0008);
        @(posedge pclk);
        check({30'h0, ref_en, main_en}, 32'h2);
        apb(1'b1, ADDR_CTRL, 32'h0000_0002);
        repeat (3) @(posedge pclk);
        check(32'(resource_enable_oe), 32'h0);
        apb(1'b1, ADDR_CTRL, 32'h0000_0000);
        rd_chk(ADDR_STATE, 32'h0000_0000);
        rd_chk(ADDR_CNT_BASE + 12'h014, 32'h0000_0000);
        // hibernate request drops the regulators
        want_hib <= 1'b0;
        repeat (3) @(posedge pclk);
        check({31'h0, regulator_enable}, 32'h0);
        check(32'(hib_out), 32'h0);
        want_hib <= 1'b1;
        want_run <= 1'b0;
        repeat (3) @(posedge pclk);
        check({30'h0, regulator_enable, core_reset_n}, 32'h0);
        results();
    end
endmodule // tb_pmu_resource_sequencer
`default_nettype wire
